// ---- design/dsfb_flag_bank.sv ----
// What this block does
// - Supply voltage word, unsigned, 100 uV steps
// - Bias current word, unsigned, 2 uA steps
// - Transmit power word, unsigned, 0.1 uW steps
// - Receive power word, unsigned, 0.1 uW steps
// - Calibration bytes 55-94 read fixed defaults
// - Byte 95 returns stored factory checksum
// - Status bit 7 shows disable pin level
// - Status bit 6 is host-writable soft disable
// - Laser off when pin OR soft bit
// - Status bit 2 shows fault output level
// - Status bit 1 shows signal-lost output level
// - Bit 0 low only when data valid
// - Commands and status act within 100 ms
// - Byte 112 bits 7/6: temperature alarms
// - Byte 112 bits 5/4: supply alarms
// - Byte 112 bits 3/2: bias alarms
// - Byte 112 bits 1/0: transmit power alarms
// - Byte 113 bits 7/6 receive alarms, rest zero
// - Byte 116 bits 7-4: temperature, supply warnings
// - Byte 116 bits 3-0: bias, transmit warnings
// - Byte 117 bits 7/6 receive warnings, rest zero
// - Temperature word signed, 1/256 degree steps
// - Live words MSB first, bytes 96-105
`timescale 1ns/100ps
`include "dsfb_regs.svh"
module dsfb_flag_bank #(
   parameter int RESP_CYCLES = `DSFB_RESP_CYCLES,
   parameter int DEPTH       = 256
) (
   input  wire logic                core_clk,
   input  wire logic                arst_n,
   input  wire dsfb_pkg::dsfb_req_t req,
   output logic [7:0]               rdata,
   output logic                     rvalid,
   input  wire dsfb_pkg::dsfb_mon_t mon,
   input  wire logic                mon_valid,
   input  wire logic                prog_enable,
   input  wire logic                tx_disable_pin,
   input  wire logic                fault_detect,
   input  wire logic                signal_lost_detect,
   output logic                     laser_disable,
   output logic                     tx_fault_output,
   output logic                     receive_signal_lost_output
);
   localparam int CW = $clog2(RESP_CYCLES + 1);
   localparam logic [CW-1:0] STALE_LIM = CW'(RESP_CYCLES - 1);
   localparam logic [31:0] FLOAT_ONE = `DSFB_FLOAT_ONE;
   localparam logic [15:0] SLOPE_ONE = `DSFB_SLOPE_ONE;
   localparam logic [4:0]  LAST_WORD = 5'(`DSFB_THR_WORDS - 1);

   logic [2:0]          sync1;
   logic [2:0]          sync2;
   logic [2:0]          sync3;
   logic [2:0]          pin_state;
   logic                soft_dis;
   dsfb_pkg::dsfb_mon_t live;
   dsfb_pkg::dsfb_mon_t snap;
   logic                pend_start;
   dsfb_pkg::dsfb_scan_t st;
   logic [4:0]          wi;
   logic [7:0]          thr_msb;
   logic [9:0]          pend_alarm;
   logic [9:0]          pend_warn;
   logic [9:0]          alarm;
   logic [9:0]          warn;
   logic                not_ready;
   logic [CW-1:0]       stale_cnt;
   logic                rd1;
   logic [7:0]          a1;
   logic [7:0]          mem_a_data;
   logic [7:0]          mem_b_data;
   logic [7:0]          scan_addr;
   logic                mem_we;
   logic [15:0]         thr_word;
   logic [15:0]         cur_val;
   logic [2:0]          grp;
   logic [3:0]          fidx;
   logic                val_gt;
   logic                val_lt;
   logic                hit;
   logic [7:0]          status;
   logic [7:0]          next_rdata;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Level changes once the second and third stage agree
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1     <= 3'h0;
         sync2     <= 3'h0;
         sync3     <= 3'h0;
         pin_state <= 3'h0;
      end else begin
         sync1     <= {tx_disable_pin, fault_detect, signal_lost_detect};
         sync2     <= sync1;
         sync3     <= sync2;
         pin_state <= (~(sync2 ^ sync3) & sync2)
                    | ((sync2 ^ sync3) & pin_state);
      end
   end

   // ----------------------------------------------------------------
   // Transmitter control and status pins
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         soft_dis <= 1'b0;
      end else if (req.wr && req.addr == `DSFB_STATUS) begin
         soft_dis <= req.wdata[`DSFB_ST_SOFT];
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         laser_disable              <= 1'b0;
         tx_fault_output            <= 1'b0;
         receive_signal_lost_output <= 1'b0;
      end else begin
         laser_disable              <= pin_state[2] | soft_dis;
         tx_fault_output            <= pin_state[1];
         receive_signal_lost_output <= pin_state[0];
      end
   end

   // ----------------------------------------------------------------
   // Live monitor capture
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         live <= '0;
      end else if (mon_valid) begin
         live <= mon;
      end
   end

   // A new sample during a scan is not lost: set beats clear
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_start <= 1'b0;
      end else if (mon_valid) begin
         pend_start <= 1'b1;
      end else if (st == dsfb_pkg::S_IDLE) begin
         pend_start <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Threshold scanner
   // ----------------------------------------------------------------
   // Words 0..19: per quantity high alarm, low alarm, high warn, low warn
   assign grp       = wi[4:2];
   assign scan_addr = {2'h0, wi, st == dsfb_pkg::S_LSB};
   assign thr_word  = {thr_msb, mem_b_data};
   assign fidx      = 4'h9 - {grp, 1'b0} - {3'h0, wi[0]};

   always_comb begin
      case (grp)
         3'h0:    cur_val = snap.temp;
         3'h1:    cur_val = snap.vcc;
         3'h2:    cur_val = snap.bias;
         3'h3:    cur_val = snap.txp;
         default: cur_val = snap.rxp;
      endcase
   end

   // Temperature compares signed, the others unsigned
   always_comb begin
      if (grp == 3'h0) begin
         val_gt = $signed(cur_val) > $signed(thr_word);
         val_lt = $signed(cur_val) < $signed(thr_word);
      end else begin
         val_gt = cur_val > thr_word;
         val_lt = cur_val < thr_word;
      end
      hit = wi[0] ? val_lt : val_gt;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st         <= dsfb_pkg::S_IDLE;
         wi         <= 5'h00;
         thr_msb    <= 8'h00;
         snap       <= '0;
         pend_alarm <= 10'h000;
         pend_warn  <= 10'h000;
      end else begin
         case (st)
            dsfb_pkg::S_IDLE: begin
               if (pend_start) begin
                  snap       <= live;
                  wi         <= 5'h00;
                  pend_alarm <= 10'h000;
                  pend_warn  <= 10'h000;
                  st         <= dsfb_pkg::S_MSB;
               end
            end
            dsfb_pkg::S_MSB: begin
               st <= dsfb_pkg::S_LSB;
            end
            dsfb_pkg::S_LSB: begin
               thr_msb <= mem_b_data;
               st      <= dsfb_pkg::S_CMP;
            end
            dsfb_pkg::S_CMP: begin
               if (wi[1]) begin
                  pend_warn[fidx] <= hit;
               end else begin
                  pend_alarm[fidx] <= hit;
               end
               if (wi == LAST_WORD) begin
                  st <= dsfb_pkg::S_DONE;
               end else begin
                  wi <= wi + 5'h01;
                  st <= dsfb_pkg::S_MSB;
               end
            end
            dsfb_pkg::S_DONE: begin
               st <= dsfb_pkg::S_IDLE;
            end
            default: begin
               st <= dsfb_pkg::S_IDLE;
            end
         endcase
      end
   end

   // All flags change together so a read never sees a half scan
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         alarm <= 10'h000;
         warn  <= 10'h000;
      end else if (st == dsfb_pkg::S_DONE) begin
         alarm <= pend_alarm;
         warn  <= pend_warn;
      end
   end

   // ----------------------------------------------------------------
   // Data-ready tracking
   // ----------------------------------------------------------------
   // Data counts as stale when no scan finished within response time
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         stale_cnt <= '0;
      end else if (st == dsfb_pkg::S_DONE) begin
         stale_cnt <= '0;
      end else if (stale_cnt != STALE_LIM) begin
         stale_cnt <= stale_cnt + CW'(1);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         not_ready <= 1'b1;
      end else if (st == dsfb_pkg::S_DONE) begin
         not_ready <= 1'b0;
      end else if (stale_cnt == STALE_LIM) begin
         not_ready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Page memory
   // ----------------------------------------------------------------
   // Factory bytes only open while prog_enable is high
   assign mem_we = req.wr
      && ((req.addr >= `DSFB_USER_FIRST && req.addr <= `DSFB_USER_LAST)
      || (prog_enable && (req.addr <= `DSFB_THR_LAST
      || req.addr == `DSFB_CHKSUM || req.addr > `DSFB_USER_LAST)));

   dsfb_mem #(
      .WIDTH     (8),
      .DEPTH     (DEPTH),
      .AW        (8)
   ) u_mem (
      .core_clk  (core_clk),
      .wr_en     (mem_we),
      .wr_addr   (req.addr),
      .wr_data   (req.wdata),
      .rd_a_addr (req.addr),
      .rd_a_data (mem_a_data),
      .rd_b_addr (scan_addr),
      .rd_b_data (mem_b_data)
   );

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   function automatic logic [7:0] cal_byte(input logic [7:0] a);
      logic [7:0] r;
      logic [7:0] k;
      r = 8'h00;
      k = a - `DSFB_RX1_FIRST;
      if (a >= `DSFB_RX1_FIRST && k < 8'h04) begin
         r = FLOAT_ONE[8'h1F - {k[4:0], 3'h0} -: 8];
      end else if (a == `DSFB_SLOPE_TXI || a == `DSFB_SLOPE_TXP
                || a == `DSFB_SLOPE_T || a == `DSFB_SLOPE_V) begin
         r = SLOPE_ONE[15:8];
      end
      return r;
   endfunction : cal_byte

   always_comb begin
      status               = 8'h00;
      status[`DSFB_ST_PIN]   = pin_state[2];
      status[`DSFB_ST_SOFT]  = soft_dis;
      status[`DSFB_ST_FAULT] = tx_fault_output;
      status[`DSFB_ST_LOS]   = receive_signal_lost_output;
      status[`DSFB_ST_NRDY]  = not_ready;
   end

   always_comb begin
      logic [7:0] j;
      logic [6:0] lb;
      j  = a1 - `DSFB_LIVE_FIRST;
      lb = 7'h4F - {j[3:0], 3'h0};
      if (a1 >= `DSFB_CAL_FIRST && a1 <= `DSFB_CAL_LAST) begin
         next_rdata = cal_byte(a1);
      end else if (a1 >= `DSFB_LIVE_FIRST && a1 <= `DSFB_LIVE_LAST) begin
         next_rdata = live[lb -: 8];
      end else begin
         case (a1)
            `DSFB_STATUS:  next_rdata = status;
            `DSFB_ALARM_A: next_rdata = alarm[9:2];
            `DSFB_ALARM_B: next_rdata = {alarm[1:0], 6'h00};
            `DSFB_WARN_A:  next_rdata = warn[9:2];
            `DSFB_WARN_B:  next_rdata = {warn[1:0], 6'h00};
            default: begin
               if (a1 >= `DSFB_RESV_FIRST && a1 <= `DSFB_RESV_LAST) begin
                  next_rdata = 8'h00;
               end else begin
                  next_rdata = mem_a_data;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd1    <= 1'b0;
         a1     <= 8'h00;
         rvalid <= 1'b0;
         rdata  <= 8'h00;
      end else begin
         rd1    <= req.rd;
         a1     <= req.addr;
         rvalid <= rd1;
         rdata  <= rd1 ? next_rdata : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking dflt_cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_rd(logic [7:0] a);
      req.rd && !req.wr && req.addr == a;
   endsequence

   sequence s_wr_status;
      req.wr && req.addr == `DSFB_STATUS;
   endsequence

   a_vcc_msb_read: assert property (
      s_rd(`DSFB_LIVE_VCC) |-> ##2 (rvalid && rdata == $past(live.vcc[15:8])))
      else $error("supply word msb mismatch");

   a_bias_lsb_read: assert property (
      s_rd(`DSFB_LIVE_BIAS_L) |-> ##2 (rdata == $past(live.bias[7:0])))
      else $error("bias word lsb mismatch");

   a_temp_msb_first: assert property (
      s_rd(`DSFB_LIVE_FIRST) |-> ##2 (rdata == $past(live.temp[15:8])))
      else $error("temperature msb not first");

   a_cal_default: assert property (
      s_rd(`DSFB_RX1_FIRST) |-> ##2 (rdata == FLOAT_ONE[31:24]))
      else $error("calibration default wrong");

   a_pin_in_status: assert property (
      s_rd(`DSFB_STATUS) |-> ##2 (rdata[7] == $past(pin_state[2])))
      else $error("status bit 7 not pin level");

   a_soft_readback: assert property (
      s_wr_status ##1 s_rd(`DSFB_STATUS)
         |-> ##2 (rdata[6] == $past(req.wdata[6], 3)))
      else $error("soft disable readback wrong");

   a_soft_kills_tx: assert property (
      (s_wr_status and req.wdata[6]) |-> ##2 laser_disable)
      else $error("laser not disabled by soft bit");

   a_ready_after_scan: assert property (
      $fell(not_ready) |-> $past(st == dsfb_pkg::S_DONE))
      else $error("ready without finished scan");

   a_stale_timeout: assert property (
      $rose(not_ready) |-> $past(stale_cnt) == STALE_LIM)
      else $error("not-ready set at wrong time");

   a_temp_high_flag: assert property (
      (st == dsfb_pkg::S_CMP && wi == 5'h00
         && $signed(snap.temp) > $signed(thr_word)) |=> pend_alarm[9])
      else $error("temperature high alarm missed");

   a_vcc_low_flag: assert property (
      (st == dsfb_pkg::S_CMP && wi == 5'h05 && snap.vcc < thr_word)
         |=> pend_alarm[6])
      else $error("supply low alarm missed");

   a_alarm_b_resv: assert property (
      s_rd(`DSFB_ALARM_B) |-> ##2 (rdata[5:0] == 6'h00))
      else $error("reserved alarm bits not zero");

endmodule : dsfb_flag_bank

// ---- design/dsfb_mem.sv ----
`timescale 1ns/100ps
module dsfb_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 256,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic             core_clk,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data,
   input  wire logic [AW-1:0]    rd_a_addr,
   output logic      [WIDTH-1:0] rd_a_data,
   input  wire logic [AW-1:0]    rd_b_addr,
   output logic      [WIDTH-1:0] rd_b_data
);
   // Non-volatile page image; contents are not reset
   logic [WIDTH-1:0] cells [DEPTH];

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         cells[wr_addr] <= wr_data;
      end
   end

   // Two registered read ports: host and threshold scanner
   always_ff @(posedge core_clk) begin
      rd_a_data <= cells[rd_a_addr];
      rd_b_data <= cells[rd_b_addr];
   end

endmodule : dsfb_mem

// ---- design/dsfb_pkg.sv ----
package dsfb_pkg;

   // Live monitor words, temperature first, each 16 bits
   typedef struct packed {
      logic [15:0] temp;
      logic [15:0] vcc;
      logic [15:0] bias;
      logic [15:0] txp;
      logic [15:0] rxp;
   } dsfb_mon_t;

   // One byte access from the management side
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } dsfb_req_t;

   typedef enum logic [2:0] {
      S_IDLE,
      S_MSB,
      S_LSB,
      S_CMP,
      S_DONE
   } dsfb_scan_t;

endpackage : dsfb_pkg

// ---- design/dsfb_regs.svh ----
`ifndef DSFB_REGS_SVH
`define DSFB_REGS_SVH

// ----------------------------------------------------------------
// Byte offsets within the diagnostic page
// ----------------------------------------------------------------
`define DSFB_THR_LAST    8'h36
`define DSFB_CAL_FIRST   8'h37
`define DSFB_CAL_LAST    8'h5E
`define DSFB_CHKSUM      8'h5F
`define DSFB_LIVE_FIRST  8'h60
`define DSFB_LIVE_LAST   8'h69
`define DSFB_LIVE_VCC    8'h62
`define DSFB_LIVE_BIAS_L 8'h65
`define DSFB_RESV_FIRST  8'h6A
`define DSFB_STATUS      8'h6E
`define DSFB_ALARM_A     8'h70
`define DSFB_ALARM_B     8'h71
`define DSFB_WARN_A      8'h74
`define DSFB_WARN_B      8'h75
`define DSFB_RESV_LAST   8'h7F
`define DSFB_USER_FIRST  8'h80
`define DSFB_USER_LAST   8'hF7

// ----------------------------------------------------------------
// Calibration defaults
// ----------------------------------------------------------------
`define DSFB_RX1_FIRST   8'h44
`define DSFB_SLOPE_TXI   8'h4C
`define DSFB_SLOPE_TXP   8'h50
`define DSFB_SLOPE_T     8'h54
`define DSFB_SLOPE_V     8'h58
`define DSFB_SLOPE_ONE   16'h0100
`define DSFB_FLOAT_ONE   32'h3F80_0000

// ----------------------------------------------------------------
// Status/control bit positions and scan size
// ----------------------------------------------------------------
`define DSFB_ST_PIN      7
`define DSFB_ST_SOFT     6
`define DSFB_ST_FAULT    2
`define DSFB_ST_LOS      1
`define DSFB_ST_NRDY     0
`define DSFB_THR_WORDS   20

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DSFB_RESP_MS     100
`define DSFB_CLK_HZ      10000000
`define DSFB_RESP_CYCLES ((`DSFB_RESP_MS * `DSFB_CLK_HZ) / 1000)

`endif

// ---- verif/dsfb_flag_bank_bench.sv ----
`timescale 1ns/100ps
`include "dsfb_regs.svh"
module dsfb_flag_bank_bench;
   typedef struct packed {
      dsfb_pkg::dsfb_mon_t m;
      logic [31:0]         f;
   } dsfb_row_t;

   logic                core_clk;
   logic                arst_n;
   dsfb_pkg::dsfb_req_t req;
   logic [7:0]          rdata;
   logic                rvalid;
   dsfb_pkg::dsfb_mon_t mon;
   logic                mon_valid;
   logic                prog_enable;
   logic                tx_disable_pin;
   logic                fault_detect;
   logic                signal_lost_detect;
   logic                laser_disable;
   logic                tx_fault_output;
   logic                receive_signal_lost_output;
   int                  bad_count;
   int                  n_tests;
   dsfb_row_t           rows [5];
   logic [15:0]         thr [4];
   logic [7:0]          rb;

   dsfb_flag_bank #(.RESP_CYCLES(200)) dut (
      .core_clk                   (core_clk),
      .arst_n                     (arst_n),
      .req                        (req),
      .rdata                      (rdata),
      .rvalid                     (rvalid),
      .mon                        (mon),
      .mon_valid                  (mon_valid),
      .prog_enable                (prog_enable),
      .tx_disable_pin             (tx_disable_pin),
      .fault_detect               (fault_detect),
      .signal_lost_detect         (signal_lost_detect),
      .laser_disable              (laser_disable),
      .tx_fault_output            (tx_fault_output),
      .receive_signal_lost_output (receive_signal_lost_output)
   );

   dsfb_host_model host (
      .core_clk (core_clk),
      .req      (req),
      .rdata    (rdata),
      .rvalid   (rvalid)
   );

   always #50 core_clk = ~core_clk;

   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", w, e, g);
      end
   endtask : chk

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      host.read_byte(a, d);
      chk($sformatf("byte %0d", a), e, d);
   endtask : rd_chk

   task automatic wait_edges(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wait_edges

   task automatic wrap_up();
      if (bad_count == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   initial begin
      wait_edges(20000);
      bad_count++;
      wrap_up();
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      core_clk = 1'b0;
      arst_n = 1'b0;
      mon = '0;
      mon_valid = 1'b0;
      prog_enable = 1'b0;
      tx_disable_pin = 1'b0;
      fault_detect = 1'b0;
      signal_lost_detect = 1'b0;
      bad_count = 0;
      n_tests = 0;
      thr = '{16'h0600, 16'h0200, 16'h0500, 16'h0300};
      // Values equal to a threshold must not raise that threshold's flag
      rows[0] = {{5{16'h0700}}, 32'hAA80_AA80};
      rows[1] = {{5{16'h0100}}, 32'h5540_5540};
      rows[2] = {{5{16'h0400}}, 32'h0000_0000};
      rows[3] = {16'hFF00, {4{16'h0400}}, 32'h4000_4000};
      rows[4] = {64'h0400_0580_0600_0200, 16'h0500, 32'h0000_2900};
      wait_edges(12);
      arst_n <= 1'b1;
      rd_chk(`DSFB_STATUS, 8'h01);
      rd_chk(`DSFB_ALARM_A, 8'h00);
      rd_chk(`DSFB_WARN_B, 8'h00);
      host.write_byte(`DSFB_STATUS, 8'hFF);
      wait_edges(3);
      chk("laser_disable", 8'h01, {7'h00, laser_disable});
      rd_chk(`DSFB_STATUS, 8'h41);
      host.write_byte(`DSFB_STATUS, 8'h00);
      wait_edges(3);
      chk("laser_disable", 8'h00, {7'h00, laser_disable});
      @(posedge core_clk);
      tx_disable_pin <= 1'b1;
      wait_edges(8);
      chk("laser_disable", 8'h01, {7'h00, laser_disable});
      rd_chk(`DSFB_STATUS, 8'h81);
      tx_disable_pin <= 1'b0;
      fault_detect <= 1'b1;
      signal_lost_detect <= 1'b1;
      wait_edges(8);
      chk("fault pin", 8'h01, {7'h00, tx_fault_output});
      chk("lost pin", 8'h01, {7'h00, receive_signal_lost_output});
      rd_chk(`DSFB_STATUS, 8'h07);
      fault_detect <= 1'b0;
      signal_lost_detect <= 1'b0;
      // Soft bit must not survive a reset in mid-run
      wait_edges(8);
      host.write_read(`DSFB_STATUS, 8'h40, rb);
      chk("status", 8'h41, rb);
      wait_edges(3);
      arst_n <= 1'b0;
      wait_edges(2);
      chk("laser_disable", 8'h00, {7'h00, laser_disable});
      arst_n <= 1'b1;
      wait_edges(8);
      rd_chk(`DSFB_STATUS, 8'h01);
      rd_chk(`DSFB_CAL_FIRST, 8'h00);
      rd_chk(`DSFB_RX1_FIRST, 8'h3F);
      rd_chk(`DSFB_SLOPE_V, 8'h01);
      prog_enable <= 1'b1;
      host.write_byte(`DSFB_RX1_FIRST, 8'h12);
      host.write_byte(`DSFB_CHKSUM, 8'hA5);
      for (int q = 0; q < 5; q++) begin
         for (int k = 0; k < 4; k++) begin
            host.write_byte(8'(q * 8 + k * 2), thr[k][15:8]);
            host.write_byte(8'(q * 8 + k * 2 + 1), thr[k][7:0]);
         end
      end
      prog_enable <= 1'b0;
      host.write_byte(`DSFB_CHKSUM, 8'h00);
      rd_chk(`DSFB_RX1_FIRST, 8'h3F);
      rd_chk(`DSFB_CHKSUM, 8'hA5);
      foreach (rows[r]) begin
         @(posedge core_clk);
         mon <= rows[r].m;
         mon_valid <= 1'b1;
         @(posedge core_clk);
         mon_valid <= 1'b0;
         wait_edges(70);
         rd_chk(`DSFB_STATUS, 8'h00);
         rd_chk(`DSFB_ALARM_A, rows[r].f[31:24]);
         rd_chk(`DSFB_ALARM_B, rows[r].f[23:16]);
         rd_chk(`DSFB_WARN_A, rows[r].f[15:8]);
         rd_chk(`DSFB_WARN_B, rows[r].f[7:0]);
         for (int j = 0; j < 10; j++) begin
            rd_chk(8'(`DSFB_LIVE_FIRST + j), rows[r].m[79-8*j -: 8]);
         end
      end
      wait_edges(250);
      rd_chk(`DSFB_STATUS, 8'h01);
      wrap_up();
   end
endmodule : dsfb_flag_bank_bench

// ---- verif/dsfb_host_model.sv ----
`timescale 1ns/100ps
module dsfb_host_model (
   input  wire logic           core_clk,
   output dsfb_pkg::dsfb_req_t req,
   input  wire logic [7:0]     rdata,
   input  wire logic           rvalid
);
   initial begin
      req = '{1'b0, 1'b0, 8'hFF, 8'hFF};
   end

   // ---------------------------------------------
   // Bus cycles
   // ---------------------------------------------
   // Idle lines show the inverse, never a stale copy of the last access
   task automatic release_bus(input logic [7:0] a, input logic [7:0] d);
      req <= '{1'b0, 1'b0, ~a, ~d};
   endtask : release_bus

   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req <= '{1'b0, 1'b1, a, d};
      @(posedge core_clk);
      release_bus(a, d);
   endtask : write_byte

   // Answer is due two edges after the strobe; a few more are allowed
   task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
      d = 8'hXX;
      @(posedge core_clk);
      req <= '{1'b1, 1'b0, a, 8'h00};
      @(posedge core_clk);
      release_bus(a, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         if (rvalid === 1'b1) begin
            d = rdata;
            break;
         end
      end
   endtask : read_byte

   // Write then read on the very next edge, no idle cycle between
   task automatic write_read(input logic [7:0] a, input logic [7:0] d,
                             output logic [7:0] q);
      q = 8'hXX;
      @(posedge core_clk);
      req <= '{1'b0, 1'b1, a, d};
      @(posedge core_clk);
      req <= '{1'b1, 1'b0, a, 8'h00};
      @(posedge core_clk);
      release_bus(a, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         if (rvalid === 1'b1) begin
            q = rdata;
            break;
         end
      end
   endtask : write_read
endmodule : dsfb_host_model
